/* verilog/tpc_regs.svh */
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH
// register byte offsets
`define TPC_OFF_MAIN      12'h000
`define TPC_OFF_PERIOD    12'h004
`define TPC_OFF_COUNT     12'h008
`define TPC_OFF_MODE      12'h00c
`define TPC_OFF_CHCTL0    12'h010
`define TPC_OFF_CMP0      12'h020
// main control field positions
`define TPC_MAIN_PS_LSB   0
`define TPC_MAIN_RST_BIT  4
`define TPC_MAIN_HALT_BIT 5
`define TPC_MAIN_WIE_BIT  6
`define TPC_MAIN_WF_BIT   7
// channel control field positions
`define TPC_CH_MAX_BIT    0
`define TPC_CH_TOV_BIT    1
`define TPC_CH_ELA_BIT    2
`define TPC_CH_ELB_BIT    3
`define TPC_CH_MSA_BIT    4
`define TPC_CH_MSB_BIT    5
`define TPC_CH_IE_BIT     6
`define TPC_CH_F_BIT      7
// system mode field positions
`define TPC_MODE_WAIT_BIT 0
`define TPC_MODE_STOP_BIT 1
`define TPC_MODE_BRK_BIT  2
`define TPC_MODE_BREAK_CLEAR_ENABLE_BIT 3
// reset values
`define TPC_RST_PERIOD    16'hffff
`define TPC_RST_MAIN      8'h20
`endif

/* verilog/tpc_pkg.sv */
package tpc_pkg;
   typedef struct packed {
      logic [7:0]  main_ctl;
      logic        wrap_flag;
      logic        wrap_armed;
      logic [15:0] period;
      logic [15:0] count;
      logic [5:0]  presc;
      logic [3:0]  sys_mode;
      logic [3:0][7:0]  chan_ctl;
      logic [3:0][15:0] cmp;
      logic [3:0]  chan_armed;
      logic [1:0]  pair_active;
      logic [1:0][15:0] pair_cmp;
      logic [1:0]  pair_pending;
      logic [3:0]  pin_out;
      logic [3:0]  cap_prev;
      logic        aw_held;
      logic [11:0] aw_addr;
      logic        w_held;
      logic [31:0] w_data;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tpc_state_t;

   typedef struct packed {
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic       wrap_irq;
      logic [3:0] chan_irq;
   } tpc_pins_t;
endpackage : tpc_pkg

/* verilog/tpc_channel_top.sv */
`timescale 1ns/1ns
`include "tpc_regs.svh"
// Summary of operation
// - unbuffered compare value takes effect at once
// - link bit pairs channels a,b onto pin a
// - last written pair set governs from wrap
// - partner control unused, partner pin released
// - link bit pairs channels c,d onto pin c
// - buffered select overrides unbuffered select
// - mode field 01 unbuffered, 10 buffered
// - level field 10 clears, 11 sets
// - no wrap toggle gives zero duty
// - max bit plus toggle gives full duty
// - wrap flag at limit, irq when enabled
// - channel flag per event, irq when enabled
// - wait keeps running, registers but mode blocked, mode write wakes
// - stop halts counting, registers kept
// - break freezes counter, blocks captures
// - break clear-enable governs flag clearing
// - armed two-step clear survives break
// - counter clear bit resets counter and prescaler
// - counter restarts from zero after limit
// - pin toggles at each wrap when enabled
// - flag clears by read then zero write
module tpc_channel_top #(
   parameter int CHANNELS = 4
) (
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   input  wire logic [11:0]      s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [11:0]      s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic             ext_tick,
   input  wire logic [3:0]       chan_pin_in,
   output tpc_pkg::tpc_pins_t    pins
);
   import tpc_pkg::*;

   tpc_state_t state;
   tpc_state_t next_state;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [2:0] reg_index(input logic [11:0] a);
      reg_index = a[4:2];
   endfunction : reg_index

   // decode of a byte address to a slot: 0..3 system, 4..7 ctl, 8..11 cmp
   function automatic logic [4:0] slot_of(input logic [11:0] a);
      logic [4:0] s;
      s = 5'h1f;
      if (a[11:5] == 7'h00 && a[4] == 1'b0)
         s = {2'b00, a[4:2]};
      else if (a[11:4] == 8'(`TPC_OFF_CHCTL0 >> 4))
         s = {3'b001, a[3:2]};
      else if (a[11:4] == 8'(`TPC_OFF_CMP0 >> 4))
         s = {3'b010, a[3:2]};
      slot_of = s;
   endfunction : slot_of

   logic        halt;
   logic        run;
   logic        tick;
   logic [2:0]  ps;
   logic        at_limit;
   logic        wr_go;
   logic        rd_go;
   logic        blocked;
   logic        in_break;
   logic        break_clear_enable;
   logic [4:0]  wslot;
   logic [4:0]  rslot;
   logic [31:0] rd_word;
   logic [3:0]  link;
   logic [3:0]  buffered;
   logic [3:0]  used;
   logic [3:0]  match;
   logic [3:0]  chan_evt;
   logic [15:0] eff_cmp [CHANNELS];

   always_comb begin
      ps       = state.main_ctl[`TPC_MAIN_PS_LSB +: 3];
      halt     = state.main_ctl[`TPC_MAIN_HALT_BIT];
      in_break = state.sys_mode[`TPC_MODE_BRK_BIT];
      break_clear_enable     = state.sys_mode[`TPC_MODE_BREAK_CLEAR_ENABLE_BIT];
      blocked  = state.sys_mode[`TPC_MODE_WAIT_BIT];
      // stop and break both freeze counting, wait does not
      run      = !halt && !state.sys_mode[`TPC_MODE_STOP_BIT] && !in_break;
      tick     = 1'b0;
      if (run) begin
         if (ps == 3'h7)
            tick = ext_tick;
         else
            tick = (ps == 3'h0) ||
                   ((state.presc & ((6'h01 << ps) - 6'h01)) == ((6'h01 << ps) - 6'h01));
      end
      at_limit = (state.count == state.period);
      link     = {1'b0, state.chan_ctl[2][`TPC_CH_MSB_BIT], 1'b0,
                  state.chan_ctl[0][`TPC_CH_MSB_BIT]};
      buffered = link;
      used     = ~{link[2], 1'b0, link[0], 1'b0};
   end

   // compare value in force for each channel
   generate
      for (genvar c = 0; c < CHANNELS; c++) begin : g_eff
         if (c == 0 || c == 2) begin : g_lead
            assign eff_cmp[c] = buffered[c] ? state.pair_cmp[c/2] : state.cmp[c];
         end else begin : g_plain
            assign eff_cmp[c] = state.cmp[c];
         end
         assign match[c] = tick && state.count == eff_cmp[c] && used[c];
      end
   endgenerate

   // ---------------------------------------------------------------
   // bus and timer state update
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      wslot      = slot_of(state.aw_addr);
      rslot      = slot_of(s_axi_araddr);
      rd_word    = 32'h0;
      chan_evt   = 4'h0;

      if (s_axi_awvalid && !state.aw_held) begin
         next_state.aw_held = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.w_held) begin
         next_state.w_held = 1'b1;
         next_state.w_data = s_axi_wdata;
      end
      wr_go = state.aw_held && state.w_held && !state.bvalid;
      rd_go = s_axi_arvalid && !state.rvalid;

      // prescaler and counter
      if (run)
         next_state.presc = state.presc + 6'h01;
      if (tick) begin
         if (at_limit) begin
            next_state.count = 16'h0;
            next_state.wrap_flag = 1'b1;
            // pending marks the set written last; kept so every later wrap reloads it
            next_state.pair_active = state.pair_pending;
            for (int p = 0; p < 2; p++) begin
               if (state.pair_pending[p])
                  next_state.pair_cmp[p] = state.cmp[2*p + 1];
               else
                  next_state.pair_cmp[p] = state.cmp[2*p];
            end
         end else begin
            next_state.count = state.count + 16'h0001;
         end
      end

      // pin logic and channel events
      for (int c = 0; c < CHANNELS; c++) begin
         logic [7:0] cc;
         cc = state.chan_ctl[c];
         if (used[c] && (buffered[c] || cc[`TPC_CH_MSA_BIT])) begin
            if (tick && at_limit && cc[`TPC_CH_TOV_BIT])
               next_state.pin_out[c] = !state.pin_out[c];
            if (match[c]) begin
               unique case (cc[`TPC_CH_ELB_BIT -: 2])
                  2'b01: next_state.pin_out[c] = !state.pin_out[c];
                  2'b10: next_state.pin_out[c] = 1'b0;
                  2'b11: next_state.pin_out[c] = 1'b1;
                  2'b00: next_state.pin_out[c] = state.pin_out[c];
               endcase
               next_state.chan_ctl[c][`TPC_CH_F_BIT] = 1'b1;
               chan_evt[c] = 1'b1;
            end
            if (cc[`TPC_CH_MAX_BIT] && cc[`TPC_CH_TOV_BIT])
               next_state.pin_out[c] = !cc[`TPC_CH_ELA_BIT];
         end else if (used[c] && !in_break && !halt &&
                      cc[`TPC_CH_ELB_BIT -: 2] != 2'b00 &&
                      chan_pin_in[c] != state.cap_prev[c] &&
                      (chan_pin_in[c] ? cc[`TPC_CH_ELA_BIT] : cc[`TPC_CH_ELB_BIT])) begin
            next_state.cmp[c] = state.count;
            next_state.chan_ctl[c][`TPC_CH_F_BIT] = 1'b1;
            chan_evt[c] = 1'b1;
         end
      end
      next_state.cap_prev = chan_pin_in;

      // register write
      if (wr_go) begin
         next_state.aw_held = 1'b0;
         next_state.w_held  = 1'b0;
         next_state.bvalid  = 1'b1;
         next_state.bresp   = 2'b00;
         if (wslot == 5'h1f || (blocked && wslot != {2'b00, reg_index(`TPC_OFF_MODE)}))
            next_state.bresp = 2'b10;
         else if (s_axi_wstrb[0]) begin
            unique case (wslot[4:2])
               3'b000: begin
                  if (wslot[1:0] == 2'b00) begin
                     next_state.main_ctl[6:0] = state.w_data[6:0] & 7'h6f;
                     if (state.w_data[`TPC_MAIN_RST_BIT]) begin
                        next_state.count = 16'h0;
                        next_state.presc = 6'h0;
                     end
                     if (!state.w_data[`TPC_MAIN_WF_BIT] && state.wrap_armed && !next_state.wrap_flag &&
                         !(in_break && !break_clear_enable))
                        next_state.wrap_flag = 1'b0;
                     else if (!state.w_data[`TPC_MAIN_WF_BIT] && state.wrap_armed &&
                              !(tick && at_limit) && !(in_break && !break_clear_enable))
                        next_state.wrap_flag = 1'b0;
                     if (!(in_break && !break_clear_enable))
                        next_state.wrap_armed = 1'b0;
                  end else if (wslot[1:0] == 2'b01) begin
                     next_state.period = state.w_data[15:0];
                  end else if (wslot[1:0] == 2'b11) begin
                     next_state.sys_mode = state.w_data[3:0];
                  end
               end
               3'b001: begin
                  for (int c = 0; c < CHANNELS; c++) begin
                     if (wslot[1:0] == 2'(c) && used[c]) begin
                        next_state.chan_ctl[c][6:0] = state.w_data[6:0];
                        if (c == 1 || c == 3)
                           next_state.chan_ctl[c][`TPC_CH_MSB_BIT] = 1'b0;
                        else if (state.w_data[`TPC_CH_MSB_BIT] && !state.chan_ctl[c][`TPC_CH_MSB_BIT])
                           next_state.pair_pending[c/2] = 1'b0;
                        // a capture or compare in the same cycle wins over the clear
                        if (!state.w_data[7] && state.chan_armed[c] &&
                            !chan_evt[c] && !(in_break && !break_clear_enable))
                           next_state.chan_ctl[c][7] = 1'b0;
                        if (!(in_break && !break_clear_enable))
                           next_state.chan_armed[c] = 1'b0;
                     end
                  end
               end
               3'b010: begin
                  next_state.cmp[wslot[1:0]] = state.w_data[15:0];
                  if (wslot[0])
                     next_state.pair_pending[wslot[1]] = 1'b1;
                  else
                     next_state.pair_pending[wslot[1]] = 1'b0;
               end
               default: next_state.bresp = 2'b10;
            endcase
         end
      end
      if (state.bvalid && s_axi_bready)
         next_state.bvalid = 1'b0;

      // register read
      if (rd_go) begin
         next_state.rvalid = 1'b1;
         next_state.rresp  = 2'b00;
         if (rslot == 5'h1f || (blocked && rslot != {2'b00, reg_index(`TPC_OFF_MODE)})) begin
            next_state.rresp = 2'b10;
         end else begin
            unique case (rslot[4:2])
               3'b000: begin
                  unique case (rslot[1:0])
                     2'b00: begin
                        rd_word = {24'h0, state.wrap_flag, state.main_ctl[6:5], 1'b0,
                                   state.main_ctl[3:0]};
                        if (state.wrap_flag && !(in_break && !break_clear_enable))
                           next_state.wrap_armed = 1'b1;
                     end
                     2'b01: rd_word = {16'h0, state.period};
                     2'b10: rd_word = {16'h0, state.count};
                     2'b11: rd_word = {28'h0, state.sys_mode};
                  endcase
               end
               3'b001: begin
                  rd_word = {24'h0, state.chan_ctl[rslot[1:0]]};
                  if (state.chan_ctl[rslot[1:0]][7] && !(in_break && !break_clear_enable))
                     next_state.chan_armed[rslot[1:0]] = 1'b1;
               end
               3'b010: rd_word = {16'h0, state.cmp[rslot[1:0]]};
               default: next_state.rresp = 2'b10;
            endcase
         end
         next_state.rdata = rd_word;
      end
      if (state.rvalid && s_axi_rready)
         next_state.rvalid = 1'b0;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state              <= '0;
         state.main_ctl     <= `TPC_RST_MAIN;
         state.period       <= `TPC_RST_PERIOD;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb begin
      s_axi_awready  = !state.aw_held;
      s_axi_wready   = !state.w_held;
      s_axi_bvalid   = state.bvalid;
      s_axi_bresp    = state.bresp;
      s_axi_arready  = !state.rvalid;
      s_axi_rvalid   = state.rvalid;
      s_axi_rdata    = state.rdata;
      s_axi_rresp    = state.rresp;
      pins.pin_out   = state.pin_out;
      // released partner pins go back to general-purpose use
      for (int c = 0; c < CHANNELS; c++)
         pins.pin_oe[c] = used[c] && (buffered[c] || state.chan_ctl[c][`TPC_CH_MSA_BIT]);
      pins.wrap_irq  = state.wrap_flag && state.main_ctl[`TPC_MAIN_WIE_BIT];
      for (int c = 0; c < CHANNELS; c++)
         pins.chan_irq[c] = state.chan_ctl[c][`TPC_CH_F_BIT] &&
                            state.chan_ctl[c][`TPC_CH_IE_BIT] && used[c];
   end
endmodule : tpc_channel_top

/* sim/tpc_load_model.sv */
`timescale 1ns/1ns
module tpc_load_model (
   input  wire logic [3:0] drv_level,
   input  wire logic [3:0] drv_en,
   input  wire logic [3:0] ext_level,
   output logic [3:0]      pin_level
);
   // a released pin is no longer ours: the load's pull-up or outside driver sets it
   assign pin_level = (drv_en & drv_level) | (~drv_en & ext_level);
endmodule : tpc_load_model

/* sim/tpc_chk_monitor.sv */
`timescale 1ns/1ns
module tpc_chk_monitor (
   input wire logic               ref_clk,
   input wire logic               sys_rst,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic [1:0]         s_axi_bresp,
   input wire logic [11:0]        s_axi_araddr,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic [1:0]         s_axi_rresp,
   input wire tpc_pkg::tpc_pins_t pins
);
   import tpc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // cycles since the last write data beat; irqs may only drop shortly after one
   logic [3:0] since_wr;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || (s_axi_wvalid && s_axi_wready)) since_wr <= 4'h0;
      else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
   end
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && !s_axi_rvalid;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_UNMAPPED: assert property (s_rd_take and s_axi_araddr > 12'h02c |=> s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   AST_RST_QUIET: assert property ($fell(sys_rst) |-> pins.pin_out == 4'h0 && !pins.wrap_irq)
      else $error("outputs active after reset");
   AST_WRAP_FALL: assert property ($fell(pins.wrap_irq) |-> since_wr <= 4'h3)
      else $error("wrap irq dropped without write");
   AST_CHAN_FALL: assert property (|(~pins.chan_irq & $past(pins.chan_irq)) |-> since_wr <= 4'h3)
      else $error("channel irq dropped without write");
endmodule : tpc_chk_monitor
bind tpc_channel_top tpc_chk_monitor tpc_chk_monitor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .pins(pins));

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import tpc_pkg::*;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        ext_tick = 1'b0;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata, rv, cnt;
   logic [3:0]  pin_in;
   logic [3:0]  ext_level = 4'hf;
   tpc_pins_t   pins;
   logic [31:0] seed = 32'h8e57;
   logic [31:0] m_reg [16];
   logic [7:0]  ctl_tab [4] = '{8'h1a, 8'h18, 8'h1b, 8'h1e};
   int          hi [4];
   int          n_errors = 0;
   int          n_tests = 0;
   always #5 ref_clk = ~ref_clk;
   tpc_channel_top tpc_channel_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_tick(ext_tick), .chan_pin_in(pin_in), .pins(pins));
   tpc_load_model tpc_load_model_inst (.drv_level(pins.pin_out), .drv_en(pins.pin_oe),
      .ext_level(ext_level), .pin_level(pin_in));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // edges of a period may land either side of a sample, so allow one cycle per period
   task automatic near(input int got, input int exp);
      chk(32'(got >= exp - 8 && got <= exp + 8), 32'h1);
   endtask : near
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n > 0 && !bready) bready <= 1'b1;
         n++;
      end while (!(bready && bvalid));
      bready <= 1'b0;
      chk(bresp, er);
      if (er == 2'b00) m_reg[a[5:2]] = d;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [1:0] er = 2'b00);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (n > 0 && !rready) rready <= 1'b1;
         n++;
      end while (!(rready && rvalid));
      rready <= 1'b0;
      rv = rdata;
      chk(rresp, er);
   endtask : rd
   task automatic meas(input int cyc);
      foreach (hi[i]) hi[i] = 0;
      repeat (cyc) begin
         @(posedge ref_clk);
         foreach (hi[i]) hi[i] += int'(pins.pin_out[i]);
      end
   endtask : meas
   task automatic report_and_stop();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
   // ----
   // main sequence
   // ----
   initial begin
      foreach (m_reg[i]) m_reg[i] = 32'h0;
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(12'h000);
      chk(rv, 32'h20);
      rd(12'h004);
      chk(rv, 32'hffff);
      rd(12'h100, 2'b10);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         wr(12'h020 + 12'(4 * c), 32'(16'(xs())));
         rd(12'h020 + 12'(4 * c));
         chk(rv, m_reg[8 + c]);
      end
      wr(12'h000, 32'h30);
      rd(12'h008);
      chk(rv, 32'h0);
      wr(12'h004, 32'hf);
      for (int c = 0; c < 4; c++) wr(12'h020 + 12'(4 * c), 32'h5);
      for (int c = 0; c < 4; c++) begin
         wr(12'h010 + 12'(4 * c), 32'(ctl_tab[c]));
         rd(12'h010 + 12'(4 * c));
         chk(rv & 32'h7f, m_reg[4 + c]);
      end
      chk(pins.pin_oe, 4'hf);
      wr(12'h000, 32'h0);
      repeat (32) @(posedge ref_clk);
      meas(128);
      near(hi[0], 8 * (m_reg[8] + 1));
      chk(hi[1], 0);
      chk(hi[2], 128);
      near(hi[3], 8 * (15 - m_reg[11]));
      wr(12'h020, 32'ha);
      repeat (32) @(posedge ref_clk);
      meas(128);
      near(hi[0], 8 * (m_reg[8] + 1));
      $display("test unbuffered done");
      wr(12'h010, 32'h3a);
      wr(12'h018, 32'h3a);
      wr(12'h014, 32'h5a);
      chk(pins.pin_oe, 4'h5);
      wr(12'h024, 32'he);
      wr(12'h02c, 32'h3);
      repeat (32) @(posedge ref_clk);
      meas(128);
      chk(pins.chan_irq[1], 1'b0);
      near(hi[0], 8 * (m_reg[9] + 1));
      near(hi[2], 8 * (m_reg[11] + 1));
      wr(12'h020, 32'h2);
      repeat (32) @(posedge ref_clk);
      meas(128);
      near(hi[0], 8 * (m_reg[8] + 1));
      $display("test buffered done");
      wr(12'h00c, 32'h1);
      rd(12'h004, 2'b10);
      meas(64);
      chk(32'(hi[0] > 0), 32'h1);
      wr(12'h00c, 32'h0);
      for (int m = 2; m <= 4; m += 2) begin
         wr(12'h00c, 32'(m));
         rd(12'h008);
         cnt = rv;
         repeat (40) @(posedge ref_clk);
         rd(12'h008);
         chk(rv, cnt);
         wr(12'h00c, 32'h0);
      end
      $display("test low power done");
      wr(12'h010, 32'h7a);
      wr(12'h000, 32'h40);
      repeat (20) @(posedge ref_clk);
      chk(pins.wrap_irq, 1'b1);
      chk(pins.chan_irq[0], 1'b1);
      wr(12'h010, 32'h3a);
      chk(pins.chan_irq[0], 1'b0);
      wr(12'h000, 32'h20);
      chk(pins.wrap_irq, 1'b0);
      wr(12'h000, 32'h60);
      chk(pins.wrap_irq, 1'b1);
      wr(12'h00c, 32'h1);
      chk(pins.wrap_irq, 1'b1);
      wr(12'h00c, 32'h0);
      rd(12'h000);
      chk(rv[7], 1'b1);
      wr(12'h00c, 32'h4);
      wr(12'h000, 32'h60);
      chk(pins.wrap_irq, 1'b1);
      wr(12'h00c, 32'h0);
      wr(12'h000, 32'h60);
      chk(pins.wrap_irq, 1'b0);
      wr(12'h000, 32'h40);
      repeat (20) @(posedge ref_clk);
      wr(12'h000, 32'h60);
      wr(12'h00c, 32'hc);
      rd(12'h000);
      wr(12'h000, 32'h60);
      chk(pins.wrap_irq, 1'b0);
      wr(12'h00c, 32'h0);
      chk(pins.wrap_irq, 1'b0);
      $display("test flags done");
      wr(12'h010, 32'h1a);
      rd(12'h014);
      wr(12'h014, 32'h04);
      wr(12'h000, 32'h00);
      for (int b = 1; b >= 0; b--) begin
         wr(12'h00c, 32'(4 * b));
         ext_level[1] <= 1'b0;
         repeat (2) @(posedge ref_clk);
         ext_level[1] <= 1'b1;
         repeat (2) @(posedge ref_clk);
         rd(12'h014);
         chk(rv[7], 32'(1 - b));
      end
      $display("test capture done");
      report_and_stop();
   end
endmodule : tb_top
